// ==== hdl/lkec_control.v ====
// Notes on behaviour
// - Bit 8 holds gate A20 state, read and write.
// - With A20 sequence active, next port 60H data is compared to bit 8.
// - Bit 5 set on D1H written to 64H, cleared by other 64H writes.
// - Bit 7 set on mouse line rising edge; write 1 clears it.
// - Bit 6 set on keyboard line rising edge; write 1 clears it.
// - Bit 4 routes controller interrupts to emulation interrupt, ignoring bit 0.
// - Bit 3 with output full drives keyboard or mouse IRQ by aux flag.
// - Bit 2 with bit 0 set raises emulation interrupt while output full is 0.
// - Bit 1 shows emulation interrupt, read only.
// - Bit 0 enables decode of ports 60H and 64H.
// - Legacy IRQ outputs only asserted with emulation enabled.
// - Emulation interrupt raised when host port activity needs service.
// - Port 60H read returns output register, then clears output full.
// - Port 60H write, unless absorbed as A20 data, loads input, sets input full, clears command flag.
// - Port 64H write loads input, sets command flag, clears input full.
// - Port 64H read returns status with no side effect.
`include "lkec_defs.vh"
module lkec_control (
  clk,
  resetn,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  io_addr,
  io_wr,
  io_rd,
  io_wdata,
  io_rdata,
  io_hit,
  kbc_kbd_irq,
  kbc_mouse_irq,
  keyboard_irq_line,
  mouse_irq_line,
  emulation_irq
);
  input wire clk;
  input wire resetn;
  input wire [11:0] reg_addr;
  input wire reg_wr;
  input wire reg_rd;
  input wire [31:0] reg_wdata;
  output reg [31:0] reg_rdata;
  input wire [15:0] io_addr;
  input wire io_wr;
  input wire io_rd;
  input wire [7:0] io_wdata;
  output reg [7:0] io_rdata;
  output wire io_hit;
  input wire kbc_kbd_irq;
  input wire kbc_mouse_irq;
  output reg keyboard_irq_line;
  output reg mouse_irq_line;
  output reg emulation_irq;

  // ==========================================
  // State
  reg gate_a20_state_r;
  reg mouse_irq_seen_r;
  reg kbd_irq_seen_r;
  reg gate_a20_sequence_active_r;
  reg external_irq_route_enable_r;
  reg legacy_irq_generate_enable_r;
  reg char_pending_r;
  reg emulation_enable_r;
  reg [7:0] legacy_input_reg_r;
  reg [7:0] legacy_output_reg_r;
  reg [7:0] legacy_status_reg_r;
  reg [7:0] status_nxt;
  reg a20_seq_nxt;

  wire [1:0] rise;
  wire ctl_wr = reg_wr && (reg_addr == `LKEC_OFS_CONTROL);
  wire in_wr = reg_wr && (reg_addr == `LKEC_OFS_INPUT);
  wire out_wr = reg_wr && (reg_addr == `LKEC_OFS_OUTPUT);
  wire st_wr = reg_wr && (reg_addr == `LKEC_OFS_STATUS);

  wire dec_60 = emulation_enable_r && (io_addr == `LKEC_IO_DATA_PORT);
  wire dec_64 = emulation_enable_r && (io_addr == `LKEC_IO_CMD_PORT);
  assign io_hit = (io_wr || io_rd) && (dec_60 || dec_64);

  wire wr_60 = io_wr && dec_60;
  wire wr_64 = io_wr && dec_64;
  wire rd_60 = io_rd && dec_60;

  // A20 data matching the held state is absorbed by hardware
  wire a20_match = gate_a20_sequence_active_r &&
                   (io_wdata[`LKEC_A20_DATA_BIT] == gate_a20_state_r);
  wire wr_60_trap = wr_60 && !a20_match;

  lkec_edge #(
    .W(2)
  ) u_edge (
    .clk(clk),
    .resetn(resetn),
    .level_in({kbc_mouse_irq, kbc_kbd_irq}),
    .rise(rise)
  );

  wire tx_loaded = legacy_status_reg_r[`LKEC_ST_TX_LOADED];
  wire aux_loaded = legacy_status_reg_r[`LKEC_ST_AUX_LOADED];

  // ==========================================
  // Emulation interrupt condition
  // Routing works even with emulation off
  wire ext_term = external_irq_route_enable_r && (kbd_irq_seen_r || mouse_irq_seen_r);
  // Character pending waits for an empty output buffer
  wire cp_term = char_pending_r && !tx_loaded;
  // Trapped port 60H writes need the emulation software
  wire svc_term = emulation_enable_r && legacy_status_reg_r[`LKEC_ST_RX_LOADED];
  wire emu_cond = ext_term || (emulation_enable_r && cp_term) || svc_term;

  // ==========================================
  // Status and sequence next values
  always @*
  begin
    status_nxt = st_wr ? reg_wdata[7:0] : legacy_status_reg_r;
    a20_seq_nxt = (ctl_wr ? reg_wdata[`LKEC_CTL_A20_SEQ] : gate_a20_sequence_active_r);
    // Reading data empties the output buffer
    if (rd_60)
      status_nxt[`LKEC_ST_TX_LOADED] = 1'b0;
    // Data write marks input full and data
    if (wr_60_trap)
    begin
      status_nxt[`LKEC_ST_RX_LOADED] = 1'b1;
      status_nxt[`LKEC_ST_CMD_DATA] = 1'b0;
    end
    // Command write sets command flag, input full to 0
    if (wr_64)
    begin
      status_nxt[`LKEC_ST_RX_LOADED] = 1'b0;
      status_nxt[`LKEC_ST_CMD_DATA] = 1'b1;
    end
    // Sequence tracks the last command byte; a port 60H write ends it
    if (wr_64)
      a20_seq_nxt = (io_wdata == `LKEC_CMD_A20_WRITE);
    else if (wr_60)
      a20_seq_nxt = 1'b0;
  end

  // ==========================================
  // Registers
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_a20_state_r <= 1'b0;
      mouse_irq_seen_r <= 1'b0;
      kbd_irq_seen_r <= 1'b0;
      gate_a20_sequence_active_r <= 1'b0;
      external_irq_route_enable_r <= 1'b0;
      legacy_irq_generate_enable_r <= 1'b0;
      char_pending_r <= 1'b0;
      emulation_enable_r <= 1'b0;
      legacy_input_reg_r <= 8'h00;
      legacy_output_reg_r <= 8'h00;
      legacy_status_reg_r <= `LKEC_ST_RESET;
      emulation_irq <= 1'b0;
      keyboard_irq_line <= 1'b0;
      mouse_irq_line <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      io_rdata <= 8'h00;
    end
    else
    begin
      if (ctl_wr)
      begin
        gate_a20_state_r <= reg_wdata[`LKEC_CTL_A20_STATE];
        external_irq_route_enable_r <= reg_wdata[`LKEC_CTL_EXT_ROUTE];
        legacy_irq_generate_enable_r <= reg_wdata[`LKEC_CTL_IRQ_GEN];
        char_pending_r <= reg_wdata[`LKEC_CTL_CP];
        emulation_enable_r <= reg_wdata[`LKEC_CTL_EE];
      end
      gate_a20_sequence_active_r <= a20_seq_nxt;
      // Mouse edge sets, write 1 clears, edge wins
      if (rise[1])
        mouse_irq_seen_r <= 1'b1;
      else if (ctl_wr && reg_wdata[`LKEC_CTL_MOUSE_SEEN])
        mouse_irq_seen_r <= 1'b0;
      // Keyboard edge sets, write 1 clears, edge wins
      if (rise[0])
        kbd_irq_seen_r <= 1'b1;
      else if (ctl_wr && reg_wdata[`LKEC_CTL_KBD_SEEN])
        kbd_irq_seen_r <= 1'b0;
      // Host writes override a same-cycle software write of the input
      if (wr_60_trap || wr_64)
        legacy_input_reg_r <= io_wdata;
      else if (in_wr)
        legacy_input_reg_r <= reg_wdata[7:0];
      if (out_wr)
        legacy_output_reg_r <= reg_wdata[7:0];
      legacy_status_reg_r <= status_nxt;
      // Registered copy of the live condition
      emulation_irq <= emu_cond;
      // IRQ choice follows the aux flag
      keyboard_irq_line <= emulation_enable_r && legacy_irq_generate_enable_r &&
                           tx_loaded && !aux_loaded;
      mouse_irq_line <= emulation_enable_r && legacy_irq_generate_enable_r &&
                        tx_loaded && aux_loaded;
      // Status read has no side effect
      if (io_rd && dec_64)
        io_rdata <= legacy_status_reg_r;
      else if (rd_60)
        io_rdata <= legacy_output_reg_r;
      if (reg_rd)
      begin
        case (reg_addr)
          `LKEC_OFS_CONTROL: reg_rdata <= {23'h0, gate_a20_state_r, mouse_irq_seen_r,
            kbd_irq_seen_r, gate_a20_sequence_active_r, external_irq_route_enable_r,
            legacy_irq_generate_enable_r, char_pending_r, emulation_irq, emulation_enable_r};
          `LKEC_OFS_INPUT: reg_rdata <= {24'h000000, legacy_input_reg_r};
          `LKEC_OFS_OUTPUT: reg_rdata <= {24'h000000, legacy_output_reg_r};
          `LKEC_OFS_STATUS: reg_rdata <= {24'h000000, legacy_status_reg_r};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // lkec_control

// ==== common/lkec_defs.vh ====
`ifndef LKEC_DEFS_VH
`define LKEC_DEFS_VH
// ==========================================
// Register byte addresses in the operational space
`define LKEC_OFS_CONTROL 12'h100
`define LKEC_OFS_INPUT 12'h104
`define LKEC_OFS_OUTPUT 12'h108
`define LKEC_OFS_STATUS 12'h10c
// ==========================================
// Control register fields
`define LKEC_CTL_EE 0
`define LKEC_CTL_EI 1
`define LKEC_CTL_CP 2
`define LKEC_CTL_IRQ_GEN 3
`define LKEC_CTL_EXT_ROUTE 4
`define LKEC_CTL_A20_SEQ 5
`define LKEC_CTL_KBD_SEEN 6
`define LKEC_CTL_MOUSE_SEEN 7
`define LKEC_CTL_A20_STATE 8
`define LKEC_CTL_RESET 32'h0000_0000
// ==========================================
// Status register fields
`define LKEC_ST_TX_LOADED 0
`define LKEC_ST_RX_LOADED 1
`define LKEC_ST_CMD_DATA 3
`define LKEC_ST_AUX_LOADED 5
`define LKEC_ST_RESET 8'h00
// ==========================================
// Emulated I/O ports and commands
`define LKEC_IO_DATA_PORT 16'h0060
`define LKEC_IO_CMD_PORT 16'h0064
`define LKEC_CMD_A20_WRITE 8'hd1
`define LKEC_A20_DATA_BIT 1
`endif

// ==== hdl/lkec_edge.v ====
// ==========================================
// Rising edge detector for the controller interrupt lines
module lkec_edge #(
  parameter W = 2
) (
  clk,
  resetn,
  level_in,
  rise
);
  input wire clk;
  input wire resetn;
  input wire [W-1:0] level_in;
  output wire [W-1:0] rise;

  reg [W-1:0] prev_r;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prev_r <= {W{1'b0}};
    else
      prev_r <= level_in;
  end

  // A line already high at reset release counts as a rising edge
  assign rise = level_in & ~prev_r;
endmodule // lkec_edge

// ==== tb/lkec_monitor.sv ====
module lkec_monitor (
  input logic clk,
  input logic resetn,
  input logic [11:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata,
  input logic [15:0] io_addr,
  input logic io_wr,
  input logic io_rd,
  input logic [7:0] io_wdata,
  input logic [7:0] io_rdata,
  input logic io_hit,
  input logic kbc_kbd_irq,
  input logic kbc_mouse_irq,
  input logic keyboard_irq_line,
  input logic mouse_irq_line,
  input logic emulation_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] sh_r;
  // ==========================================
  // Shadow of software bits; host cycles never touch them
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      sh_r <= 5'h00;
    else if (reg_wr && reg_addr == 12'h100)
      sh_r <= reg_wdata[4:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_nohit; !sh_r[0] |-> !io_hit; endproperty
  a_nohit: assert property (p_nohit) else $error("decode while off");
  property p_hit; sh_r[0] && io_wr && io_addr == 16'h0064 |-> io_hit; endproperty
  a_hit: assert property (p_hit) else $error("port not decoded");
  property p_leg; !$past(sh_r[0]) |-> !keyboard_irq_line && !mouse_irq_line; endproperty
  a_leg: assert property (p_leg) else $error("legacy irq while off");
  property p_excl; !(keyboard_irq_line && mouse_irq_line); endproperty
  a_excl: assert property (p_excl) else $error("both legacy irqs");
  property p_ei; !$past(sh_r[0]) && !$past(sh_r[4]) |-> !emulation_irq; endproperty
  a_ei: assert property (p_ei) else $error("stray emulation irq");
  property p_rsv; $past(reg_rd && reg_addr == 12'h100) |-> reg_rdata[31:9] == 23'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_unm; $past(reg_rd && reg_addr == 12'h000) |-> reg_rdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  property p_eird;
    $past(reg_rd && reg_addr == 12'h100) |-> reg_rdata[1] == $past(emulation_irq);
  endproperty
  a_eird: assert property (p_eird) else $error("bit1 mismatch");
  c_hit: cover property (io_hit && io_wr);
  c_kbd: cover property (keyboard_irq_line);
  c_mouse: cover property (mouse_irq_line);
endmodule // lkec_monitor
bind lkec_control lkec_monitor lkec_monitor_inst (
  .clk(clk),
  .resetn(resetn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .io_addr(io_addr),
  .io_wr(io_wr),
  .io_rd(io_rd),
  .io_wdata(io_wdata),
  .io_rdata(io_rdata),
  .io_hit(io_hit),
  .kbc_kbd_irq(kbc_kbd_irq),
  .kbc_mouse_irq(kbc_mouse_irq),
  .keyboard_irq_line(keyboard_irq_line),
  .mouse_irq_line(mouse_irq_line),
  .emulation_irq(emulation_irq)
);

// ==== tb/lkec_kbc_model.sv ====
module lkec_kbc_model (
  input logic clk,
  input logic resetn,
  input logic [1:0] kick,
  output logic kbd_line,
  output logic mouse_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] k_r, m_r;
  // ==========================================
  // Each kick gives a four cycle pulse, long enough to be an edge
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      {k_r, m_r} <= 8'h00;
    else
      {k_r, m_r} <= {k_r[2:0], kick[0], m_r[2:0], kick[1]};
  assign kbd_line = |k_r;
  assign mouse_line = |m_r;
endmodule // lkec_kbc_model

// ==== tb/tb_legacy_kbd_emulation_control.sv ====
module tb_legacy_kbd_emulation_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, reg_wr, reg_rd, io_wr, io_rd, io_hit, emulation_irq;
  logic kbc_kbd_irq, kbc_mouse_irq, keyboard_irq_line, mouse_irq_line;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic [1:0] kick;
  int miscompares, n_compared;
`define LKEC_CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
  lkec_control lkec_control_inst (
    .clk(clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .io_hit(io_hit),
    .kbc_kbd_irq(kbc_kbd_irq),
    .kbc_mouse_irq(kbc_mouse_irq),
    .keyboard_irq_line(keyboard_irq_line),
    .mouse_irq_line(mouse_irq_line),
    .emulation_irq(emulation_irq)
  );
  lkec_kbc_model lkec_kbc_model_inst (.clk(clk), .resetn(resetn), .kick(kick),
    .kbd_line(kbc_kbd_irq), .mouse_line(kbc_mouse_irq));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================
  // Access tasks
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic r(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `LKEC_CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic o(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic h);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= wr;
    io_rd <= !wr;
    #1 `LKEC_CHK("io_hit", h, io_hit)
    @(posedge clk);
    {io_wr, io_rd} <= 2'b00;
    #1 if (!wr) `LKEC_CHK("io_rdata", d, io_rdata)
  endtask
  task automatic end_of_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {resetn, reg_wr, reg_rd, io_wr, io_rd, kick} = 7'h00;
    {reg_addr, reg_wdata, io_addr, io_wdata} = 68'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    r(12'h100, 32'h0);
    r(12'h000, 32'h0);
    w(12'h100, 32'hffff_ffdf);
    r(12'h100, 32'h0000_011f);
    `LKEC_CHK("emulation_irq", 1'b1, emulation_irq)
    w(12'h100, 32'h1);
    o(1'b1, 16'h64, 8'hd1, 1'b1);
    r(12'h100, 32'h21);
    o(1'b0, 16'h64, 8'h08, 1'b1);
    o(1'b1, 16'h60, 8'h02, 1'b1);
    r(12'h104, 32'h02);
    o(1'b0, 16'h64, 8'h02, 1'b1);
    r(12'h100, 32'h03);
    o(1'b1, 16'h64, 8'hd1, 1'b1);
    o(1'b1, 16'h60, 8'h00, 1'b1);
    r(12'h104, 32'hd1);
    o(1'b1, 16'h64, 8'hd1, 1'b1);
    o(1'b1, 16'h64, 8'h55, 1'b1);
    r(12'h100, 32'h01);
    w(12'h108, 32'h5a);
    w(12'h10c, 32'h01);
    w(12'h100, 32'h09);
    repeat (2) @(posedge clk);
    #1 `LKEC_CHK("keyboard_irq_line", 1'b1, keyboard_irq_line)
    w(12'h10c, 32'h21);
    repeat (2) @(posedge clk);
    #1 `LKEC_CHK("mouse_irq_line", 1'b1, mouse_irq_line)
    o(1'b0, 16'h60, 8'h5a, 1'b1);
    r(12'h10c, 32'h20);
    w(12'h100, 32'h0);
    o(1'b1, 16'h64, 8'h33, 1'b0);
    r(12'h104, 32'h55);
    w(12'h100, 32'h10);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      kick <= 2'b01 << i;
      @(posedge clk);
      kick <= 2'b00;
      repeat (6) @(posedge clk);
      r(12'h100, 32'h12 | (32'h40 << i));
      w(12'h100, 32'h10 | (32'h40 << i));
      r(12'h100, 32'h10);
    end
    end_of_test;
  end
endmodule // tb_legacy_kbd_emulation_control
